// >>> hdl/vcr_regs.sv
/*
 * vcr_regs: capability, control and table-status registers of the second
 * virtual channel, plus the 128-phase port arbitration table it loads.
 * Assumes synchronous inputs, a strap that is stable from reset release,
 * and a master that never issues read and write in the same cycle.
 */
`timescale 1ns/10ps

// Contract
// - arbitration capability 19h or 00h by strap
// - round robin, weighted, time-based weighted supported
// - advanced switching only bit reads zero
// - snoop rejection bit reads zero
// - time slots 7Fh by strap, autoload replaceable
// - table offset 08h by strap
// - traffic class map writable, resets 00h
// - map bit zero stays zero
// - load bit applies table, reads zero
// - select accepts 000b 011b 100b else default
// - channel identifier writable, 001b by strap
// - channel enable bit, resets disabled
// - table status set on write, cleared after load
module vcr_regs #(
    parameter int TBL_DEPTH = 16
) (
    // clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    // strap
    input  wire logic              STRAP_PRESENT,
    // register port
    input  wire vcr_pkg::vcr_req_t REQ,
    output logic [31:0]            RDATA,
    // eeprom autoload
    input  wire vcr_pkg::vcr_auto_t AUTO,
    // channel configuration
    output vcr_pkg::vcr_cfg_t      CFG,
    output logic [31:0]            ARB_WORD,
    output logic [3:0]             ARB_IDX,
    output logic                   ARB_WE,
    output logic                   CFG_READY
);

    typedef struct packed {
        vcr_pkg::vcr_state_t st;
        logic                strap;
        logic [6:0]          slots;
        logic [7:0]          map;
        logic [2:0]          sel;
        logic [2:0]          id;
        logic                en;
        logic                tbl_dirty;
        logic [3:0]          idx;
        logic [3:0]          widx;
        logic [31:0]         word;
        logic                we;
        logic [31:0]         rdata;
    } vcr_regs_t;

    vcr_regs_t r;
    vcr_regs_t next_r;
    logic [31:0] tbl [TBL_DEPTH];
    logic        tbl_hit;
    logic [3:0]  tbl_wi;
    logic        live;
    logic        wr_live;
    logic        rd_live;
    logic        hit_cap;
    logic        hit_ctrl;
    logic        hit_stat;
    logic        tbl_wr;
    logic        load_req;
    logic        load_done;

    // anything else collapses to default, so a read never shows a bad code
    // legal arbitration codes
    function automatic logic [2:0] sel_filter(input logic [2:0] code);
        if (code == vcr_pkg::SEL_WRR128 || code == vcr_pkg::SEL_TWRR128) begin
            return code;
        end
        return vcr_pkg::SEL_RR;
    endfunction

    // read image of the capability register
    function automatic logic [31:0] cap_image(input logic s, input logic [6:0] sl);
        logic [31:0] v;
        v = '0;
        if (s) begin
            v[vcr_pkg::CAP_ARB_LO +: 8]  = vcr_pkg::ARB_CAP_ON;
            v[vcr_pkg::CAP_TOFS_LO +: 8] = vcr_pkg::TBL_OFS_ON;
        end
        v[vcr_pkg::CAP_SLOT_LO +: 7] = sl;
        v[vcr_pkg::CAP_ASO_BIT]      = 1'b0;
        v[vcr_pkg::CAP_SNP_BIT]      = 1'b0;
        return v;
    endfunction

    // read image of the control register; the load bit is a strobe
    function automatic logic [31:0] ctrl_image(
        input logic [7:0] m,
        input logic [2:0] s,
        input logic [2:0] i,
        input logic       e
    );
        logic [31:0] v;
        v = '0;
        v[vcr_pkg::CTL_MAP_LO +: 8] = m;
        v[vcr_pkg::CTL_SEL_LO +: 3] = s;
        v[vcr_pkg::CTL_ID_LO +: 3]  = i;
        v[vcr_pkg::CTL_EN_BIT]      = e;
        return v;
    endfunction

    // read image of the table status register
    function automatic logic [31:0] stat_image(input logic d);
        logic [31:0] v;
        v = '0;
        v[vcr_pkg::STAT_TBL_BIT] = d;
        return v;
    endfunction

    // strap dependent reset value of the time slot count
    function automatic logic [6:0] strap_slots(input logic s);
        logic [6:0] v;
        v = '0;
        if (s) begin
            v = vcr_pkg::SLOTS_ON;
        end
        return v;
    endfunction

    // strap dependent reset value of the channel identifier
    function automatic logic [2:0] strap_id(input logic s);
        logic [2:0] v;
        v = '0;
        if (s) begin
            v = vcr_pkg::CHAN_ID_ON;
        end
        return v;
    endfunction

    // traffic class zero never maps here, whoever writes the map
    function automatic logic [7:0] map_keep(input logic [7:0] m);
        return m & vcr_pkg::MAP_WR_MASK;
    endfunction

    // table window, byte offsets alias to their word, except 1FDh to 1FFh which fall outside
    function automatic logic in_table(input logic [11:0] a);
        return (a >= vcr_pkg::OFF_TBL_DATA) && (a <= vcr_pkg::OFF_TBL_LAST);
    endfunction

    // address decode; strobes before strap capture are dropped
    assign live     = (r.st != vcr_pkg::VCR_ST_STRAP);
    assign wr_live  = REQ.wr && live;
    assign rd_live  = REQ.rd && live;
    assign hit_cap  = (REQ.addr == vcr_pkg::OFF_CAP);
    assign hit_ctrl = (REQ.addr == vcr_pkg::OFF_CTRL);
    assign hit_stat = (REQ.addr == vcr_pkg::OFF_TBL_STAT);
    assign tbl_hit  = in_table(REQ.addr);
    assign tbl_wi   = REQ.addr[5:2];
    assign tbl_wr   = wr_live && tbl_hit;

    assign load_req  = wr_live && hit_ctrl && REQ.wdata[vcr_pkg::CTL_LOAD_BIT];
    assign load_done = (r.st == vcr_pkg::VCR_ST_LOAD) && (r.idx == vcr_pkg::TBL_LAST_IDX);

    // table array, software writes only; entries are not cleared by reset
    always_ff @(posedge CLK_SYS) begin
        if (tbl_wr) begin
            tbl[tbl_wi] <= REQ.wdata;
        end
    end

    // next state; read data and the beat strobe last one cycle only
    always_comb begin
        next_r       = r;
        next_r.we    = 1'b0;
        next_r.rdata = '0;

        // sequencer: strap capture, idle, table streaming
        case (r.st)
            vcr_pkg::VCR_ST_STRAP: begin
                next_r.strap = STRAP_PRESENT;
                next_r.slots = strap_slots(STRAP_PRESENT);
                next_r.id    = strap_id(STRAP_PRESENT);
                next_r.st    = vcr_pkg::VCR_ST_IDLE;
            end
            vcr_pkg::VCR_ST_IDLE: begin
                next_r.st = vcr_pkg::VCR_ST_IDLE;
            end
            vcr_pkg::VCR_ST_LOAD: begin
                next_r.word = tbl[r.idx];
                next_r.widx = r.idx;
                next_r.we   = 1'b1;
                next_r.idx  = r.idx + 4'h1;
                if (load_done) begin
                    next_r.st = vcr_pkg::VCR_ST_IDLE;
                end
            end
            default: begin
                // a broken state code recovers to idle, the strap stays as taken
                next_r.st = vcr_pkg::VCR_ST_IDLE;
            end
        endcase

        if (live && AUTO.slot_we) begin
            next_r.slots = AUTO.slot;
        end
        if (live && AUTO.map_we) begin
            next_r.map = map_keep(AUTO.map);
        end

        // control write; coming later, software beats a same-cycle autoload
        if (wr_live && hit_ctrl) begin
            next_r.map = map_keep(REQ.wdata[vcr_pkg::CTL_MAP_LO +: 8]);
            next_r.sel = sel_filter(REQ.wdata[vcr_pkg::CTL_SEL_LO +: 3]);
            next_r.id  = REQ.wdata[vcr_pkg::CTL_ID_LO +: 3];
            next_r.en  = REQ.wdata[vcr_pkg::CTL_EN_BIT];
        end

        // load request starts a new pass
        if (load_req) begin
            next_r.st  = vcr_pkg::VCR_ST_LOAD;
            next_r.idx = '0;
        end

        if (load_done) begin
            next_r.tbl_dirty = 1'b0;
        end
        // dirty on entry write, set wins over a same-cycle clear
        if (tbl_wr) begin
            next_r.tbl_dirty = 1'b1;
        end

        // read mux, unmapped and reserved read zero
        if (rd_live) begin
            if (hit_cap) begin
                next_r.rdata = cap_image(r.strap, r.slots);
            end else if (hit_ctrl) begin
                next_r.rdata = ctrl_image(r.map, r.sel, r.id, r.en);
            end else if (hit_stat) begin
                next_r.rdata = stat_image(r.tbl_dirty);
            end else if (tbl_hit) begin
                next_r.rdata = tbl[tbl_wi];
            end
        end
    end

    // state register, constants only under reset
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            r       <= '0;
            r.st    <= vcr_pkg::VCR_ST_STRAP;
            r.map   <= vcr_pkg::MAP_RESET;
            r.sel   <= vcr_pkg::SEL_RR;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign RDATA     = r.rdata;
    assign CFG.map   = r.map;
    assign CFG.sel   = r.sel;
    assign CFG.id    = r.id;
    assign CFG.en    = r.en;
    assign ARB_WORD  = r.word;
    assign ARB_IDX   = r.widx;                      // registered beside the word it names
    assign ARB_WE    = r.we;
    assign CFG_READY = (r.st != vcr_pkg::VCR_ST_STRAP);

endmodule

// >>> shared/vcr_pkg.sv
/*
 * vcr_pkg: register offsets, field positions, reset values and the
 * carrier structs of the second channel's resource register bank.
 * Assumes a plain one-cycle register port with read data a cycle later.
 */
package vcr_pkg;

    // register byte offsets
    localparam logic [11:0] OFF_CAP      = 12'h15C;
    localparam logic [11:0] OFF_CTRL     = 12'h160;
    localparam logic [11:0] OFF_TBL_STAT = 12'h164;
    localparam logic [11:0] OFF_TBL_DATA = 12'h1C0;
    localparam logic [11:0] OFF_TBL_LAST = 12'h1FC;

    // capability field positions
    localparam int CAP_ARB_LO   = 0;
    localparam int CAP_ASO_BIT  = 14;
    localparam int CAP_SNP_BIT  = 15;
    localparam int CAP_SLOT_LO  = 16;
    localparam int CAP_TOFS_LO  = 24;

    // control field positions
    localparam int CTL_MAP_LO   = 0;
    localparam int CTL_LOAD_BIT = 16;
    localparam int CTL_SEL_LO   = 17;
    localparam int CTL_ID_LO    = 24;
    localparam int CTL_EN_BIT   = 31;

    // status field position
    localparam int STAT_TBL_BIT = 16;

    // strap dependent values (strap high), map reset value and map write mask
    localparam logic [7:0] ARB_CAP_ON   = 8'h19;
    localparam logic [6:0] SLOTS_ON     = 7'h7F;
    localparam logic [7:0] TBL_OFS_ON   = 8'h08;
    localparam logic [2:0] CHAN_ID_ON   = 3'h1;
    localparam logic [7:0] MAP_RESET    = 8'h00;
    localparam logic [7:0] MAP_WR_MASK  = 8'hFE;

    // arbitration select codes
    localparam logic [2:0] SEL_RR       = 3'h0;
    localparam logic [2:0] SEL_WRR128   = 3'h3;
    localparam logic [2:0] SEL_TWRR128  = 3'h4;

    // table load takes one cycle per table word
    localparam int TBL_WORDS = 16;
    localparam logic [3:0] TBL_LAST_IDX = 4'hF;

    typedef enum logic [2:0] {
        VCR_ST_STRAP = 3'b001,
        VCR_ST_IDLE  = 3'b010,
        VCR_ST_LOAD  = 3'b100
    } vcr_state_t;

    // register access request
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } vcr_req_t;

    // autoload overrides from the serial eeprom loader
    typedef struct packed {
        logic       slot_we;
        logic [6:0] slot;
        logic       map_we;
        logic [7:0] map;
    } vcr_auto_t;

    // values the channel logic consumes
    typedef struct packed {
        logic [7:0] map;
        logic [2:0] sel;
        logic [2:0] id;
        logic       en;
    } vcr_cfg_t;

endpackage

// >>> verification/tb_top.sv
/* tb_top: register level bench for vcr_regs.
   assumes the package is compiled first and the checker is bound. */
`timescale 1ns/10ps
module tb_top;
    logic               clk_sys = 1'b0;
    logic               nrst = 1'b0;
    logic               strap = 1'b1;
    vcr_pkg::vcr_req_t  req = '0;
    vcr_pkg::vcr_auto_t au = '0;
    vcr_pkg::vcr_cfg_t  cfg;
    logic [31:0]        rdata;
    logic [31:0]        arb_word;
    logic [3:0]         arb_idx;
    logic               arb_we;
    logic               cfg_ready;
    int                 fail_count = 0;
    int                 tests_run = 0;
    int                 i;

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    vcr_regs dut (.CLK_SYS(clk_sys), .NRST(nrst), .STRAP_PRESENT(strap), .REQ(req),
        .RDATA(rdata), .AUTO(au), .CFG(cfg), .ARB_WORD(arb_word), .ARB_IDX(arb_idx),
        .ARB_WE(arb_we), .CFG_READY(cfg_ready));

    task automatic complete_run;
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // single cycle write strobe; nothing comes back
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        req <= '{a, 32'h0, 1'b0, 1'b1};
        @(posedge clk_sys);
        req.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask

    // reset for five cycles, then a bounded wait for strap capture
    task automatic do_reset(input logic s);
        nrst <= 1'b0;
        strap <= s;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        for (i = 0; i < 8 && cfg_ready !== 1'b1; i++)
            @(posedge clk_sys);
        if (cfg_ready !== 1'b1) begin
            fail_count++;
            complete_run();
        end
    endtask

    initial begin
        do_reset(1'b1);
        rd(12'h15C, 32'h087F0019);
        rd(12'h160, 32'h01000000);
        chk({31'h0, cfg.en}, 32'h0);
        // capability is read-only
        wr(12'h15C, 32'hFFFFFFFF);
        rd(12'h15C, 32'h087F0019);
        // all ones: bit 0, reserved and load bits drop, bad select defaults
        wr(12'h160, 32'hFFFFFFFF);
        rd(12'h160, 32'h870000FE);
        chk({31'h0, cfg.en}, 32'h1);
        // every select code; only the three schemes are kept
        for (int c = 0; c < 8; c++) begin
            wr(12'h160, 32'(c) << 17);
            rd(12'h160, (c == 0 || c == 3 || c == 4) ? 32'(c) << 17 : 32'h0);
        end
        // time-based weighted scheme is held on this channel
        wr(12'h160, 32'h00080000);
        #1 chk({29'h0, cfg.sel}, 32'h4);
        // table write marks status; load applies word 0 and clears it
        wr(12'h1C0, 32'hA5C30F96);
        rd(12'h164, 32'h00010000);
        wr(12'h160, 32'h00010000);
        // first beat shows a cycle after the load state is entered
        @(posedge clk_sys);
        #1 chk({arb_we, 27'h0, arb_idx}, 32'h80000000);
        chk(arb_word, 32'hA5C30F96);
        repeat (15) @(posedge clk_sys);
        #1 chk({arb_we, 27'h0, arb_idx}, 32'h8000000F);
        rd(12'h164, 32'h0);
        // eeprom autoload of slots and map; map bit 0 forced low
        @(posedge clk_sys);
        au <= '{1'b1, 7'h12, 1'b1, 8'hFF};
        @(posedge clk_sys);
        au <= '0;
        rd(12'h15C, 32'h08120019);
        chk({24'h0, cfg.map}, 32'hFE);
        // unmapped address
        wr(12'h100, 32'hFFFFFFFF);
        rd(12'h100, 32'h0);
        // strap low in a second reset
        do_reset(1'b0);
        rd(12'h15C, 32'h0);
        rd(12'h160, 32'h0);
        complete_run();
    end
endmodule

// >>> verification/vcr_properties.sv
/* vcr_properties: port timing checks for vcr_regs.
   assumes it is bound to every vcr_regs instance. */
`timescale 1ns/10ps
module vcr_properties (
    // clock, reset, strap
    input wire logic              CLK_SYS,
    input wire logic              NRST,
    input wire logic              STRAP_PRESENT,
    // register port and channel outputs
    input wire vcr_pkg::vcr_req_t REQ,
    input wire logic [31:0]       RDATA,
    input wire vcr_pkg::vcr_cfg_t CFG,
    input wire logic [3:0]        ARB_IDX,
    input wire logic              ARB_WE,
    input wire logic              CFG_READY
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // only taken requests count; strobes before strap capture are ignored
    wire logic rd_cap = REQ.rd && CFG_READY && REQ.addr == 12'h15C;
    wire logic rd_ctl = REQ.rd && CFG_READY && REQ.addr == 12'h160;
    wire logic wr_ctl = REQ.wr && CFG_READY && REQ.addr == 12'h160;
    a_ready_after_strap: assert property (!CFG_READY |=> CFG_READY)
        else $error("ready not raised after strap capture");
    a_cap_image: assert property ($past(rd_cap) |->
        RDATA[15:8] == 8'h00 && !RDATA[23] && RDATA[7:0] == (STRAP_PRESENT ? 8'h19 : 8'h00))
        else $error("capability image wrong");
    a_aso_zero: assert property ($past(rd_cap) |-> !RDATA[14])
        else $error("advanced switching only bit set");
    a_snoop_zero: assert property ($past(rd_cap) |-> !RDATA[15])
        else $error("snoop rejection bit set");
    a_tbl_offset: assert property ($past(rd_cap) |->
        RDATA[31:24] == (STRAP_PRESENT ? 8'h08 : 8'h00))
        else $error("table offset wrong");
    a_ctrl_reserved: assert property ($past(rd_ctl) |-> (RDATA & 32'h78F1FF00) == 0)
        else $error("control reserved or load bit read nonzero");
    a_map_bit0: assert property (CFG.map[0] == 1'b0)
        else $error("map bit 0 set");
    a_sel_legal: assert property (CFG.sel inside {3'h0, 3'h3, 3'h4})
        else $error("illegal select code held");
    a_map_write: assert property (wr_ctl |=> CFG.map == ($past(REQ.wdata[7:0]) & 8'hFE))
        else $error("map not taken from write");
    a_id_en_write: assert property (wr_ctl |=> CFG.id == $past(REQ.wdata[26:24])
        && CFG.en == $past(REQ.wdata[31]))
        else $error("identifier or enable not taken from write");
    a_load_burst: assert property (wr_ctl && REQ.wdata[16] |=> ##1
        (ARB_WE && ARB_IDX == 4'h0) ##15 (ARB_WE && ARB_IDX == 4'hF))
        else $error("table load burst wrong");
    // main scenarios
    c_load: cover property (wr_ctl && REQ.wdata[16]);
    c_cap_read: cover property ($past(rd_cap));
    c_ready: cover property ($rose(CFG_READY));
endmodule

bind vcr_regs vcr_properties u_props (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .STRAP_PRESENT(STRAP_PRESENT), .REQ(REQ), .RDATA(RDATA), .CFG(CFG),
    .ARB_IDX(ARB_IDX), .ARB_WE(ARB_WE), .CFG_READY(CFG_READY));
